// >>> rtl/can_acceptance_mask_regs.sv
// Added by the designer: register access over AXI4-Lite and the register offsets.
`timescale 1ns/1ns
// How it works
// R1: Low byte bits 7-5, 1-0 hold identifier mask
// R2: Low byte bits 4 and 2 read zero
// R3: Bit 3 exists in modes 1, 2 and 3, not in mode 0
// R4: Type enable set: filter type must match
// R5: Type enable clear: both frame types accepted
// R6: High byte holds extended mask bits 15-8
// R7: Extended low register holds mask bits 7-0
// R8: Mask one compares bit, zero ignores it
module can_acceptance_mask_regs #(
	parameter int unsigned NUM_MASKS = can_mask_pkg::NUM_MASKS
) (
	input wire logic core_clk_i,
	input wire logic arst_n_i,
	input wire logic [11:0] s_axi_awaddr_i,
	input wire logic s_axi_awvalid_i,
	output logic s_axi_awready_o,
	input wire logic [31:0] s_axi_wdata_i,
	input wire logic [3:0] s_axi_wstrb_i,
	input wire logic s_axi_wvalid_i,
	output logic s_axi_wready_o,
	output logic [1:0] s_axi_bresp_o,
	output logic s_axi_bvalid_o,
	input wire logic s_axi_bready_i,
	input wire logic [11:0] s_axi_araddr_i,
	input wire logic s_axi_arvalid_i,
	output logic s_axi_arready_o,
	output logic [31:0] s_axi_rdata_o,
	output logic [1:0] s_axi_rresp_o,
	output logic s_axi_rvalid_o,
	input wire logic s_axi_rready_i,
	// Received frame and the filter it is checked against
	input wire logic [28:0] rx_identifier_i,
	input wire logic rx_extended_i,
	input wire logic [28:0] filter_identifier_i,
	input wire logic filter_extended_i,
	input wire logic [0:0] mask_select_i,
	output logic frame_accept_o
);
	typedef struct packed {
		logic [NUM_MASKS-1:0][7:0] std_low;
		logic [NUM_MASKS-1:0][7:0] ext_high;
		logic [NUM_MASKS-1:0][7:0] ext_low;
		logic [NUM_MASKS-1:0][7:0] high_std;
		logic [1:0] mode;
		logic aw_held;
		logic [11:0] aw_addr;
		logic w_held;
		logic [31:0] w_data;
		logic w_strb0;
		logic bvalid;
		logic [1:0] bresp;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
		logic accept;
	} state_s;

	state_s q;
	state_s d;

	// Resolves an address to a mask set and register; ok is low when unmapped
	function automatic logic [4:0] decode(input logic [11:0] addr);
		logic [11:0] rel;
		logic [4:0] res;
		res = 5'h00;
		rel = addr;
		for (int unsigned n = 0; n < NUM_MASKS; n++) begin
			rel = addr - 12'(n) * can_mask_pkg::MASK_STRIDE;
			if (rel == can_mask_pkg::OFS_STD_LOW) res = {1'b1, 1'(n), 3'h0};
			if (rel == can_mask_pkg::OFS_EXT_HIGH) res = {1'b1, 1'(n), 3'h1};
			if (rel == can_mask_pkg::OFS_EXT_LOW) res = {1'b1, 1'(n), 3'h2};
			if (rel == can_mask_pkg::OFS_HIGH_STD) res = {1'b1, 1'(n), 3'h3};
		end
		if (addr == can_mask_pkg::OFS_MODE) res = {1'b1, 1'b0, 3'h4};
		return res;
	endfunction

	logic [4:0] wdec;
	logic [4:0] rdec;
	logic [28:0] full_mask;
	logic [7:0] low_wmask;
	logic [7:0] low_rd;

	assign s_axi_awready_o = !q.aw_held && !q.bvalid;
	assign s_axi_wready_o = !q.w_held && !q.bvalid;
	assign s_axi_arready_o = !q.rvalid;
	assign s_axi_bvalid_o = q.bvalid;
	assign s_axi_bresp_o = q.bresp;
	assign s_axi_rvalid_o = q.rvalid;
	assign s_axi_rdata_o = q.rdata;
	assign s_axi_rresp_o = q.rresp;
	assign frame_accept_o = q.accept;

	always_comb begin
		logic aw_now;
		logic w_now;
		logic [11:0] wa;
		logic [31:0] wd;
		logic ws;
		logic [0:0] mi;
		aw_now = 1'b0;
		w_now = 1'b0;
		wa = 12'h000;
		wd = 32'h0000_0000;
		ws = 1'b0;
		mi = 1'b0;
		d = q;
		low_wmask = (q.mode == 2'h0) ? can_mask_pkg::STD_LOW_WMASK_M0 :
			can_mask_pkg::STD_LOW_WMASK_M12; // see R3
		aw_now = q.aw_held || s_axi_awvalid_i;
		w_now = q.w_held || s_axi_wvalid_i;
		wa = q.aw_held ? q.aw_addr : s_axi_awaddr_i;
		wd = q.w_held ? q.w_data : s_axi_wdata_i;
		ws = q.w_held ? q.w_strb0 : s_axi_wstrb_i[0];
		wdec = decode(wa);
		if (s_axi_awvalid_i && s_axi_awready_o) begin
			d.aw_held = 1'b1;
			d.aw_addr = s_axi_awaddr_i;
		end
		if (s_axi_wvalid_i && s_axi_wready_o) begin
			d.w_held = 1'b1;
			d.w_data = s_axi_wdata_i;
			d.w_strb0 = s_axi_wstrb_i[0];
		end
		if (aw_now && w_now && !q.bvalid) begin
			d.aw_held = 1'b0;
			d.w_held = 1'b0;
			d.bvalid = 1'b1;
			d.bresp = wdec[4] ? can_mask_pkg::RESP_OKAY : can_mask_pkg::RESP_SLVERR;
			mi = wdec[3];
			if (wdec[4] && ws) begin
				unique case (wdec[2:0])
					3'h0: d.std_low[mi] = wd[7:0] & low_wmask; // see R1 see R2 see R3
					3'h1: d.ext_high[mi] = wd[7:0]; // see R6
					3'h2: d.ext_low[mi] = wd[7:0]; // see R7
					3'h3: d.high_std[mi] = wd[7:0];
					default: d.mode = wd[1:0];
				endcase
			end
		end
		if (q.bvalid && s_axi_bready_i) d.bvalid = 1'b0;
		// Leaving mode 0 must not expose a stale type enable
		if (d.mode == 2'h0) begin
			for (int unsigned n = 0; n < NUM_MASKS; n++) begin
				d.std_low[n][can_mask_pkg::STD_LOW_TYPE_EN_BIT] = 1'b0; // see R3
			end
		end
		rdec = decode(s_axi_araddr_i);
		mi = rdec[3];
		low_rd = q.std_low[mi] & low_wmask; // see R2 see R3
		if (s_axi_arvalid_i && s_axi_arready_o) begin
			d.rvalid = 1'b1;
			d.rresp = rdec[4] ? can_mask_pkg::RESP_OKAY : can_mask_pkg::RESP_SLVERR;
			d.rdata = 32'h0000_0000;
			if (rdec[4]) begin
				unique case (rdec[2:0])
					3'h0: d.rdata[7:0] = low_rd;
					3'h1: d.rdata[7:0] = q.ext_high[mi];
					3'h2: d.rdata[7:0] = q.ext_low[mi];
					3'h3: d.rdata[7:0] = q.high_std[mi];
					default: d.rdata[1:0] = q.mode;
				endcase
			end
		end else if (q.rvalid && s_axi_rready_i) begin
			d.rvalid = 1'b0;
		end
		// Identifier layout: bits 28-18 standard part, 17-0 extension
		mi = mask_select_i;
		full_mask = {q.high_std[mi],
			q.std_low[mi][can_mask_pkg::STD_LOW_SID_MSB:can_mask_pkg::STD_LOW_SID_LSB],
			q.std_low[mi][can_mask_pkg::STD_LOW_EID_MSB:can_mask_pkg::STD_LOW_EID_LSB],
			q.ext_high[mi], q.ext_low[mi]}; // see R1 see R6 see R7
		d.accept = (((rx_identifier_i ^ filter_identifier_i) & full_mask) == 29'h0); // see R8
		if (q.mode != 2'h0 &&
			q.std_low[mi][can_mask_pkg::STD_LOW_TYPE_EN_BIT] &&
			rx_extended_i != filter_extended_i) begin
			d.accept = 1'b0; // see R4
		end
		// With the enable clear the frame type plays no part, see R5
	end

	always_ff @(posedge core_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			q <= '0;
			for (int unsigned n = 0; n < NUM_MASKS; n++) begin
				q.std_low[n] <= can_mask_pkg::STD_LOW_RESET;
				q.ext_high[n] <= can_mask_pkg::EXT_HIGH_RESET;
				q.ext_low[n] <= can_mask_pkg::EXT_LOW_RESET;
				q.high_std[n] <= can_mask_pkg::HIGH_STD_RESET;
			end
			q.mode <= can_mask_pkg::MODE_RESET;
		end else begin
			q <= d;
		end
	end
endmodule

// >>> rtl/can_mask_pkg.sv
package can_mask_pkg;
	localparam int unsigned NUM_MASKS = 2;
	// One 32-bit word per register; mask set n adds n times the stride
	localparam logic [11:0] OFS_STD_LOW = 12'h000;
	localparam logic [11:0] OFS_EXT_HIGH = 12'h004;
	localparam logic [11:0] OFS_EXT_LOW = 12'h008;
	localparam logic [11:0] OFS_HIGH_STD = 12'h00C;
	localparam logic [11:0] MASK_STRIDE = 12'h010;
	localparam logic [11:0] OFS_MODE = 12'h040;
	// Field positions in the mask low-byte register
	localparam int unsigned STD_LOW_SID_MSB = 7;
	localparam int unsigned STD_LOW_SID_LSB = 5;
	localparam int unsigned STD_LOW_TYPE_EN_BIT = 3;
	localparam int unsigned STD_LOW_EID_MSB = 1;
	localparam int unsigned STD_LOW_EID_LSB = 0;
	// Writable bits of the low byte in mode 0 and in modes 1 to 3
	localparam logic [7:0] STD_LOW_WMASK_M0 = 8'hE3;
	localparam logic [7:0] STD_LOW_WMASK_M12 = 8'hEB;
	localparam logic [7:0] STD_LOW_RESET = 8'h00;
	localparam logic [7:0] EXT_HIGH_RESET = 8'h00;
	localparam logic [7:0] EXT_LOW_RESET = 8'h00;
	localparam logic [7:0] HIGH_STD_RESET = 8'h00;
	localparam logic [1:0] MODE_RESET = 2'h0;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// >>> dv/can_mask_chk.sv
`timescale 1ns/1ns
module can_mask_chk (
	input wire logic core_clk_i, arst_n_i, s_axi_awvalid_i, s_axi_awready_o,
	input wire logic s_axi_wvalid_i, s_axi_wready_o, s_axi_bvalid_o, s_axi_bready_i,
	input wire logic s_axi_arvalid_i, s_axi_arready_o, s_axi_rvalid_o, s_axi_rready_i,
	input wire logic rx_extended_i, filter_extended_i, frame_accept_o,
	input wire logic [31:0] s_axi_rdata_o,
	input wire logic [28:0] rx_identifier_i, filter_identifier_i
);
	default clocking @(posedge core_clk_i); endclocking
	default disable iff (!arst_n_i);
	a_read_next: assert property (s_axi_arvalid_i && s_axi_arready_o |=> s_axi_rvalid_o)
		else $error("read late");
	a_read_hold: assert property (s_axi_rvalid_o && !s_axi_rready_i |=> s_axi_rvalid_o)
		else $error("read dropped");
	a_read_upper: assert property (s_axi_rvalid_o |-> s_axi_rdata_o[31:8] == 24'h0)
		else $error("upper bits set");
	a_read_block: assert property (s_axi_rvalid_o |-> !s_axi_arready_o)
		else $error("second read");
	a_write_next: assert property (s_axi_awvalid_i && s_axi_awready_o
		&& s_axi_wvalid_i && s_axi_wready_o |=> s_axi_bvalid_o) else $error("write late");
	a_write_hold: assert property (s_axi_bvalid_o && !s_axi_bready_i |=> s_axi_bvalid_o)
		else $error("response dropped");
	a_write_block: assert property (s_axi_bvalid_o |-> !s_axi_awready_o && !s_axi_wready_o)
		else $error("second write");
	a_match_accept: assert property (rx_identifier_i == filter_identifier_i
		&& rx_extended_i == filter_extended_i |=> frame_accept_o) else $error("match refused");
	c_read_stall: cover property (s_axi_rvalid_o && !s_axi_rready_i);
	c_accept: cover property (frame_accept_o);
	c_reject: cover property ($fell(frame_accept_o));
endmodule
bind can_acceptance_mask_regs can_mask_chk i_can_mask_chk (.*);

// >>> dv/can_frame_src.sv
`timescale 1ns/1ns
module can_frame_src (
	input wire logic core_clk_i,
	input wire logic extended_i,
	input wire logic [28:0] id_i,
	input wire logic [28:0] flip_i,
	output logic [28:0] rx_identifier_o = 29'h0,
	output logic rx_extended_o = 1'b0
);
	// A frame identifier differs from its filter only where flip_i marks corrupted bits
	always @(posedge core_clk_i) begin
		rx_identifier_o <= id_i ^ flip_i;
		rx_extended_o <= extended_i;
	end
endmodule

// >>> dv/can_acceptance_mask_regs_test.sv
`timescale 1ns/1ns
module can_acceptance_mask_regs_test;
	logic core_clk_i = 0, arst_n_i = 0, s_axi_awvalid_i = 0, s_axi_wvalid_i = 0, e, ev, dn;
	logic s_axi_bready_i = 0, s_axi_arvalid_i = 0, s_axi_rready_i = 0, filter_extended_i = 0;
	logic s_axi_awready_o, s_axi_wready_o, s_axi_bvalid_o, s_axi_arready_o, s_axi_rvalid_o;
	logic rx_extended_i, frame_accept_o, ext = 0;
	logic [11:0] s_axi_awaddr_i = 0, s_axi_araddr_i = 0, a;
	logic [31:0] s_axi_wdata_i = 0, s_axi_rdata_o, x = 32'h97B9839C, d, r;
	logic [28:0] rx_identifier_i, filter_identifier_i = 0, pf = 0, flip = 0;
	logic [3:0] s_axi_wstrb_i = 0;
	logic [1:0] s_axi_bresp_o, s_axi_rresp_o, md = 0;
	logic [0:0] mask_select_i = 0;
	logic [7:0] m [2][4] = '{default: 8'h00};
	int bad_count = 0, num_checks = 0, cyc = 0;
	always #10 core_clk_i = ~core_clk_i;
	can_acceptance_mask_regs i_can_acceptance_mask_regs (.*);
	can_frame_src i_can_frame_src (.core_clk_i, .id_i(pf), .flip_i(flip), .extended_i(ext),
		.rx_identifier_o(rx_identifier_i), .rx_extended_o(rx_extended_i));
	function automatic logic [31:0] xs();
		x ^= x << 13;
		x ^= x >> 17;
		x ^= x << 5;
		return x;
	endfunction
	task automatic chk(input logic [31:0] g, input logic [31:0] w);
		num_checks++;
		if (g !== w) begin
			bad_count++;
			$display("MISMATCH %0t %h %h", $time, g, w);
		end
	endtask
	task automatic chk_acc(input logic g, input logic w);
		chk({31'h0, g}, {31'h0, w});
	endtask
	task automatic end_of_test();
		$display("checks %0d bad %0d", num_checks, bad_count);
		if (bad_count == 0 && num_checks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	always @(posedge core_clk_i)
		if (++cyc == 9000) begin
			bad_count++;
			end_of_test();
		end
	// Ready is read before the edge's own updates land, so release never races the design
	task automatic bus(input logic w);
		s_axi_awaddr_i <= a;
		s_axi_araddr_i <= a;
		s_axi_wdata_i <= d;
		s_axi_wstrb_i <= d[11:8];
		s_axi_awvalid_i <= w;
		s_axi_wvalid_i <= w;
		s_axi_arvalid_i <= !w;
		do begin
			@(posedge core_clk_i);
			dn = w ? s_axi_bvalid_o & s_axi_bready_i : s_axi_rvalid_o & s_axi_rready_i;
			r = w ? {30'h0, s_axi_bresp_o} : s_axi_rdata_o;
			if (s_axi_awvalid_i & s_axi_awready_o) s_axi_awvalid_i <= 0;
			if (s_axi_wvalid_i & s_axi_wready_o) s_axi_wvalid_i <= 0;
			if (s_axi_arvalid_i & s_axi_arready_o) s_axi_arvalid_i <= 0;
			s_axi_bready_i <= s_axi_bvalid_o & !dn;
			s_axi_rready_i <= s_axi_rvalid_o & !dn;
		end while (!dn);
	endtask
	function automatic logic acc();
		logic [7:0] l;
		l = m[mask_select_i][0];
		return ((rx_identifier_i ^ filter_identifier_i) & {m[mask_select_i][3], l[7:5], l[1:0],
			m[mask_select_i][1], m[mask_select_i][2]}) == 0
			&& !(md != 0 && l[3] && rx_extended_i != filter_extended_i);
	endfunction
	initial begin
		repeat (10) @(posedge core_clk_i);
		arst_n_i <= 1;
		repeat (150) begin
			@(posedge core_clk_i);
			d = xs();
			a = d[11:0] & 12'h05C;
			d = xs();
			bus(1);
			chk(r, {30'h0, (a < 12'h020 || a == 12'h040) ? 2'h0 : 2'h2});
			if (d[8] && a == 12'h040) md = d[1:0];
			if (d[8] && a < 12'h020) m[a[4]][a[3:2]] = d[7:0] & (a[3:2] != 0 ? 8'hFF : md != 0 ? 8'hEB : 8'hE3);
			m[0][0][3] &= md != 0;
			m[1][0][3] &= md != 0;
			bus(0);
			chk(r, a == 12'h040 ? {30'h0, md} : a < 12'h020 ? {24'h0, m[a[4]][a[3:2]]} : 32'h0);
			ev = 0;
			repeat (12) begin
				@(posedge core_clk_i);
				d = xs();
				filter_identifier_i <= pf;
				pf <= d[28:0];
				flip <= d[31] ? 29'h0 : d[28:0] & d[30:2];
				filter_extended_i <= d[29];
				ext <= d[30];
				mask_select_i <= d[3:3];
				@(negedge core_clk_i);
				if (ev) chk_acc(frame_accept_o, e);
				e = acc();
				ev = 1;
			end
		end
		end_of_test();
	end
endmodule
